// ===== design/power_mode_wake_control.sv
// power state, wake and reboot controller with apb registers
`timescale 1ns/100ps
`include "pmw_consts.svh"

// Behaviour
// - auto regulator choice, optional linear only
// - lf source crystal, rc or external
// - rc source recalibrated every eight seconds
// - reboot on power-up or reset
// - enabled pin change wakes to active
// - standby also wakes on rtc, radio, sensor
// - standby keeps ram and low-power peripherals
// - sleep halts core, rtc and peripherals (rc calibration keeps running), limited wake sources
// - latched pins wake on any change
// - sleep exit reboots, retained ram kept
// - any pin may control sleep
// - brown-out shuts down without saving
// - optional temperature range shutdown
// - reset pin low resets without saving
// - soft poweroff saves then resets
// - modem-ready input switches on/off with save
// - rtc raises events in active and standby
// - tag interface passive only
// - radio events run without cpu
module power_mode_wake_control #(
    parameter int NPIN     = 25,
    parameter int CAL_CYC  = `PMW_CAL_TICKS
) (
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 reset_pin_n,
    input  wire logic                 supply_ok,
    input  wire logic                 temp_out_of_range,
    input  wire logic [NPIN-1:0]      gpio_in,
    input  wire logic                 modem_ready,
    input  wire logic                 stock_fw,
    input  wire logic                 lf_osc_in,
    input  wire logic                 lf_osc_out,
    input  wire logic                 radio_event,
    input  wire logic                 tag_field_detect,
    input  wire logic                 lp_comp_event,
    input  wire logic                 sensor_event,
    input  wire logic                 save_done,
    output logic                      linear_regulator_mode,
    output logic                      buck_en,
    output logic                      rc_osc_en,
    output logic                      xtal_drive_en,
    output logic                      rc_cal_start,
    output logic                      core_reset_n,
    output logic                      ram_retain_all,
    output logic [7:0]                ram_retain_sect,
    output logic                      periph_lp_en,
    output logic                      save_req,
    output logic                      detach_req,
    output logic                      rtc_event,
    output logic                      tag_passive_only,
    output pmw_pkg::pstate_e          power_state
);
    import pmw_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [11:0]     ctrl_reg;
    logic [NPIN-1:0] wake_en_reg;
    logic [31:0]     rtc_cmp_reg;
    logic [31:0]     rtc_cnt_reg;
    logic [7:0]      retain_reg;
    logic [7:0]      load_reg;
    logic [1:0]      cmd_pulse;
    logic [3:0]      cause_reg;
    pstate_e         st_reg;
    logic [NPIN-1:0] latch_reg;
    logic [NPIN-1:0] pin_clean;
    logic [NPIN-1:0] pin_prev_reg;
    logic [15:0]     div_reg;
    logic            lf_tick;
    logic [31:0]     cal_reg;
    logic [7:0]      tmr_reg;
    logic            modem_prev_reg;
    logic            save_for_off_reg;
    logic            sleep_pin_prev_reg;
    logic            wr_en;
    logic            pin_wake;
    logic            sleep_pin;
    logic            modem_edge;
    logic            sleep_pin_edge;

    function automatic logic addr_ok(input logic [11:0] a);
        addr_ok = (a <= `PMW_A_LOAD) && (a[1:0] == 2'h0);
    endfunction

    assign wr_en = psel && penable && pwrite && pready;

    // ****************************************
    // apb slave: one wait state, answer on second access cycle
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok(paddr);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else if (psel && penable && !pready) begin
            case (paddr)
                `PMW_A_CTRL:    prdata <= {20'h0, ctrl_reg};
                `PMW_A_WAKE_EN: prdata <= 32'(wake_en_reg);
                `PMW_A_STATUS:  prdata <= {25'h0, cause_reg, 3'(st_reg)};
                `PMW_A_RTC_CMP: prdata <= rtc_cmp_reg;
                `PMW_A_RTC_CNT: prdata <= rtc_cnt_reg;
                `PMW_A_RETAIN:  prdata <= {24'h0, retain_reg};
                `PMW_A_LOAD:    prdata <= {24'h0, load_reg};
                default:        prdata <= 32'h0;
            endcase
        end
    end

    // configuration survives core resets; only rstn clears it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg    <= `PMW_CTRL_RESET;
            wake_en_reg <= '0;
            rtc_cmp_reg <= 32'hFFFFFFFF;
            retain_reg  <= 8'h00;
            load_reg    <= 8'h00;
            cmd_pulse   <= 2'h0;
        end else begin
            cmd_pulse <= 2'h0;
            if (wr_en && !pslverr) begin
                case (paddr)
                    `PMW_A_CTRL:    ctrl_reg    <= pwdata[11:0];
                    `PMW_A_WAKE_EN: wake_en_reg <= pwdata[NPIN-1:0];
                    `PMW_A_CMD:     cmd_pulse   <= pwdata[1:0];
                    `PMW_A_RTC_CMP: rtc_cmp_reg <= pwdata;
                    `PMW_A_RETAIN:  retain_reg  <= pwdata[7:0];
                    `PMW_A_LOAD:    load_reg    <= pwdata[7:0];
                    default:        cmd_pulse   <= 2'h0;
                endcase
            end
        end
    end

    // ****************************************
    // low-frequency tick and rc calibration
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 16'h0;
            lf_tick <= 1'b0;
        end else begin
            lf_tick <= (div_reg == 16'(`PMW_LF_DIV - 1));
            div_reg <= (div_reg == 16'(`PMW_LF_DIV - 1)) ? 16'h0 : div_reg + 16'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rc_osc_en     <= 1'b0;
            xtal_drive_en <= 1'b0;
        end else begin
            rc_osc_en     <= (ctrl_reg[`PMW_CTRL_LFSEL] == 2'(LF_RC));
            xtal_drive_en <= (ctrl_reg[`PMW_CTRL_LFSEL] == 2'(LF_CRYSTAL));
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cal_reg      <= 32'h0;
            rc_cal_start <= 1'b0;
        end else begin
            rc_cal_start <= 1'b0;
            if (ctrl_reg[`PMW_CTRL_LFSEL] != 2'(LF_RC)) begin
                cal_reg <= 32'h0;
            end else if (lf_tick) begin
                if (cal_reg == 32'(CAL_CYC - 1)) begin
                    cal_reg      <= 32'h0;
                    rc_cal_start <= 1'b1;
                end else begin
                    cal_reg <= cal_reg + 32'h1;
                end
            end
        end
    end

    // ****************************************
    // rtc: counts on lf ticks in active and standby
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rtc_cnt_reg <= 32'h0;
            rtc_event   <= 1'b0;
        end else begin
            rtc_event <= 1'b0;
            if (lf_tick && (st_reg == PS_ACTIVE || st_reg == PS_STANDBY)) begin
                if (rtc_cnt_reg == rtc_cmp_reg) begin
                    rtc_cnt_reg <= 32'h0;
                    rtc_event   <= 1'b1;
                end else begin
                    rtc_cnt_reg <= rtc_cnt_reg + 32'h1;
                end
            end
        end
    end

    // ****************************************
    // pin wake detection
    // ****************************************
    pin_wake_filter #(.N(NPIN)) u_filter (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .lf_tick   (lf_tick),
        .pin_in    (gpio_in),
        .pin_clean (pin_clean)
    );

    assign sleep_pin = pin_clean[ctrl_reg[`PMW_CTRL_SLEEP_PIN]];
    assign sleep_pin_edge = ctrl_reg[`PMW_CTRL_PIN_CTL_EN] && (sleep_pin != sleep_pin_prev_reg);
    assign modem_edge = stock_fw && (modem_ready != modem_prev_reg);
    // a latched pin that moves wakes regardless of its enable
    assign pin_wake = |(((pin_clean ^ pin_prev_reg) & wake_en_reg) |
                        ((pin_clean ^ latch_reg) & {NPIN{ctrl_reg[`PMW_CTRL_LATCH_EN]}}
                         & {NPIN{st_reg == PS_SLEEP}}));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_prev_reg       <= '0;
            modem_prev_reg     <= 1'b0;
            sleep_pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg       <= pin_clean;
            modem_prev_reg     <= modem_ready;
            sleep_pin_prev_reg <= sleep_pin;
        end
    end

    // ****************************************
    // power state machine
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg           <= PS_OFF;
            tmr_reg          <= 8'h0;
            latch_reg        <= '0;
            cause_reg        <= 4'h0;
            save_for_off_reg <= 1'b0;
        end else if (!supply_ok) begin
            st_reg    <= PS_OFF;
            cause_reg <= 4'h1;
        end else if (!reset_pin_n) begin
            st_reg  <= PS_BOOT;
            tmr_reg <= 8'h0;
            cause_reg <= 4'h2;
        end else if (ctrl_reg[`PMW_CTRL_TEMP_EN] && temp_out_of_range &&
                     st_reg != PS_SHUTDOWN && st_reg != PS_OFF && st_reg != PS_SLEEP) begin
            // sleep halts the sensor as well, so sleep is left only by a wake, the reset pin or a brown-out
            st_reg    <= PS_SHUTDOWN;
            cause_reg <= 4'h3;
        end else begin
            case (st_reg)
                PS_OFF: begin
                    st_reg  <= PS_BOOT;
                    tmr_reg <= 8'h0;
                end
                PS_BOOT: begin
                    tmr_reg <= tmr_reg + 8'h1;
                    if (tmr_reg == 8'(`PMW_BOOT_CYC - 1))
                        st_reg <= PS_ACTIVE;
                end
                PS_ACTIVE: begin
                    if (cmd_pulse == `PMW_CMD_POWEROFF || modem_edge) begin
                        st_reg           <= PS_SAVE;
                        save_for_off_reg <= modem_edge && !modem_ready;
                        tmr_reg          <= 8'h0;
                    end else if (cmd_pulse == `PMW_CMD_SLEEP || sleep_pin_edge) begin
                        st_reg    <= PS_SLEEP;
                        latch_reg <= pin_clean;
                    end else if (cmd_pulse == `PMW_CMD_STANDBY) begin
                        st_reg <= PS_STANDBY;
                    end
                end
                PS_STANDBY: begin
                    if (pin_wake || rtc_event || radio_event || tag_field_detect ||
                        lp_comp_event || (ctrl_reg[`PMW_CTRL_SENS_EN] && sensor_event)) begin
                        st_reg    <= PS_ACTIVE;
                        cause_reg <= 4'h4;
                    end
                end
                PS_SLEEP: begin
                    if (pin_wake || sleep_pin_edge || lp_comp_event || tag_field_detect ||
                        (modem_edge && modem_ready)) begin
                        st_reg    <= PS_BOOT;
                        tmr_reg   <= 8'h0;
                        cause_reg <= 4'h5;
                    end
                end
                PS_SAVE: begin
                    tmr_reg <= tmr_reg + 8'h1;
                    if (save_done || tmr_reg == 8'(`PMW_SAVE_CYC - 1)) begin
                        st_reg    <= save_for_off_reg ? PS_SLEEP : PS_BOOT;
                        latch_reg <= pin_clean;
                        tmr_reg   <= 8'h0;
                        cause_reg <= 4'h6;
                    end
                end
                PS_SHUTDOWN: begin
                    if (!temp_out_of_range) begin
                        st_reg  <= PS_BOOT;
                        tmr_reg <= 8'h0;
                    end
                end
                default: st_reg <= PS_OFF;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            linear_regulator_mode <= 1'b1;
            buck_en               <= 1'b0;
            core_reset_n          <= 1'b0;
            ram_retain_all        <= 1'b0;
            ram_retain_sect       <= 8'h00;
            periph_lp_en          <= 1'b0;
            save_req              <= 1'b0;
            detach_req            <= 1'b0;
            tag_passive_only      <= 1'b1;
            power_state           <= PS_OFF;
        end else begin
            buck_en <= !ctrl_reg[`PMW_CTRL_LDO_ONLY] && st_reg == PS_ACTIVE &&
                       load_reg >= `PMW_HEAVY_LOAD;
            linear_regulator_mode <= ctrl_reg[`PMW_CTRL_LDO_ONLY] || st_reg != PS_ACTIVE ||
                                     load_reg < `PMW_HEAVY_LOAD;
            core_reset_n    <= (st_reg == PS_ACTIVE || st_reg == PS_STANDBY);
            ram_retain_all  <= (st_reg == PS_STANDBY);
            ram_retain_sect <= retain_reg;
            periph_lp_en    <= (st_reg == PS_STANDBY);
            save_req        <= (st_reg == PS_SAVE);
            detach_req      <= (st_reg == PS_SAVE);
            tag_passive_only <= 1'b1;
            power_state     <= st_reg;
        end
    end

    a_poweroff_saves: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_reg == PS_ACTIVE && cmd_pulse == `PMW_CMD_POWEROFF && supply_ok && reset_pin_n
         && !(ctrl_reg[`PMW_CTRL_TEMP_EN] && temp_out_of_range)) |=> ##1 save_req)
        else $error("poweroff did not request save");
    a_brownout_off: assert property (@(posedge core_clk) disable iff (!rstn)
        !supply_ok |=> st_reg == PS_OFF) else $error("brown-out not off");
    a_reset_pin_boot: assert property (@(posedge core_clk) disable iff (!rstn)
        (supply_ok && !reset_pin_n) |=> (st_reg == PS_BOOT) ##1 !save_req)
        else $error("reset pin did not reboot");
    a_ldo_forced: assert property (@(posedge core_clk) disable iff (!rstn)
        ctrl_reg[`PMW_CTRL_LDO_ONLY] |=> !buck_en) else $error("buck on in ldo mode");
    a_sleep_reboots: assert property (@(posedge core_clk) disable iff (!rstn)
        ($past(st_reg) == PS_SLEEP && st_reg != PS_SLEEP) |-> st_reg inside {PS_BOOT, PS_OFF})
        else $error("sleep exit without reboot");
    a_temp_shutdown: assert property (@(posedge core_clk) disable iff (!rstn)
        (supply_ok && reset_pin_n && ctrl_reg[`PMW_CTRL_TEMP_EN] && temp_out_of_range &&
         st_reg == PS_ACTIVE) |=> st_reg == PS_SHUTDOWN) else $error("no temp shutdown");
    a_rtc_halted: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_reg == PS_SLEEP && $past(st_reg) == PS_SLEEP) |-> $stable(rtc_cnt_reg))
        else $error("rtc ran in sleep");
    a_standby_keeps: assert property (@(posedge core_clk) disable iff (!rstn)
        st_reg == PS_STANDBY |=> ram_retain_all && periph_lp_en)
        else $error("standby lost retention");
    c_sleep_wake: cover property (@(posedge core_clk) st_reg == PS_SLEEP ##1 st_reg == PS_BOOT);
    c_standby_wake: cover property (@(posedge core_clk)
        st_reg == PS_STANDBY ##1 st_reg == PS_ACTIVE);
    c_rc_cal: cover property (@(posedge core_clk) rc_cal_start);
endmodule // power_mode_wake_control

// ===== design/pmw_consts.svh
// register offsets, field positions, reset values and timing counts of the power controller
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH
`define PMW_CLK_HZ          20000000
`define PMW_LF_HZ           32768
`define PMW_CAL_S           8
`define PMW_CAL_TICKS       (`PMW_CAL_S * `PMW_LF_HZ)
`define PMW_LF_DIV          ((`PMW_CLK_HZ + `PMW_LF_HZ - 1) / `PMW_LF_HZ)
`define PMW_BOOT_CYC        16
`define PMW_SAVE_CYC        8
`define PMW_HEAVY_LOAD      8'h80
`define PMW_A_CTRL          12'h000
`define PMW_A_WAKE_EN       12'h004
`define PMW_A_STATUS        12'h008
`define PMW_A_CMD           12'h00C
`define PMW_A_RTC_CMP       12'h010
`define PMW_A_RTC_CNT       12'h014
`define PMW_A_RETAIN        12'h018
`define PMW_A_LOAD          12'h01C
`define PMW_CTRL_LDO_ONLY   0
`define PMW_CTRL_LFSEL      2:1
`define PMW_CTRL_LATCH_EN   3
`define PMW_CTRL_TEMP_EN    4
`define PMW_CTRL_SLEEP_PIN  9:5
`define PMW_CTRL_PIN_CTL_EN 10
`define PMW_CTRL_SENS_EN    11
`define PMW_CTRL_RESET      12'h000
`define PMW_CMD_STANDBY     2'h1
`define PMW_CMD_SLEEP       2'h2
`define PMW_CMD_POWEROFF    2'h3
`endif

// ===== design/pmw_pkg.sv
// types shared by the power controller
package pmw_pkg;
    typedef enum logic [1:0] {LF_CRYSTAL, LF_RC, LF_EXT_CLK, LF_RSVD} lf_src_e;
    typedef enum logic [2:0] {PS_OFF, PS_BOOT, PS_ACTIVE, PS_STANDBY, PS_SLEEP, PS_SAVE,
                              PS_SHUTDOWN} pstate_e;
endpackage

// ===== design/pin_wake_filter.sv
// per-pin wake filter: synchronise to the lf tick and drop glitches below one lf period
`timescale 1ns/100ps
module pin_wake_filter #(
    parameter int N = 25
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         lf_tick,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] pin_clean
);
    logic [N-1:0] s1_reg;
    logic [N-1:0] s2_reg;
    logic [N-1:0] s3_reg;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            // two-stage synchroniser; only s2 reads s1
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    s1_reg[i] <= 1'b0;
                    s2_reg[i] <= 1'b0;
                end else begin
                    s1_reg[i] <= pin_in[i];
                    s2_reg[i] <= s1_reg[i];
                end
            end
            // level must agree on two lf ticks before it is accepted
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    s3_reg[i]    <= 1'b0;
                    pin_clean[i] <= 1'b0;
                end else if (lf_tick) begin
                    s3_reg[i] <= s2_reg[i];
                    if (s3_reg[i] == s2_reg[i])
                        pin_clean[i] <= s2_reg[i];
                end
            end
        end
    endgenerate
endmodule // pin_wake_filter

// ===== test/host_wake_model.sv
// model of the host side: reset pin, supply monitor and low-frequency clock
`timescale 1ns/100ps
module host_wake_model (
    input  wire logic core_clk,
    input  wire logic hold_reset,
    input  wire logic drop_supply,
    output logic      reset_pin_n,
    output logic      supply_ok,
    output logic      lf_osc_in,
    output logic      lf_osc_out
);
    // ****************************************
    // pins
    // ****************************************
    // idles high, as the pull-up holds it when nobody pulls it down
    initial begin
        reset_pin_n = 1'b1;
        supply_ok   = 1'b1;
        forever begin
            @(posedge core_clk);
            reset_pin_n <= !hold_reset;
            supply_ok   <= !drop_supply;
        end
    end
    // free-running 32.768 kHz reference, well inside 250 ppm
    initial begin
        lf_osc_in = 1'b0;
        forever #15258.8 lf_osc_in = !lf_osc_in;
    end
    assign lf_osc_out = !lf_osc_in;
endmodule // host_wake_model

// ===== test/tb.sv
// self-checking testbench of the power mode and wake controller
`timescale 1ns/100ps
module tb;
    import pmw_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    typedef struct {logic w; logic [11:0] a; logic [31:0] d, m, x; logic e;} row_s;
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic hold_reset = 0, drop_supply = 0, temp_out_of_range = 0, modem_ready = 1;
    logic radio_event = 0, tag_field_detect = 0, pready, pslverr, er, hit;
    logic lp_comp_event = 0, sensor_event = 0;
    logic reset_pin_n, supply_ok, lf_osc_in, lf_osc_out, linear_regulator_mode, buck_en;
    logic rc_osc_en, xtal_drive_en, rc_cal_start, core_reset_n, ram_retain_all;
    logic periph_lp_en, save_req, detach_req, rtc_event, tag_passive_only;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [24:0] gpio_in = '0;
    logic [7:0]  ram_retain_sect;
    pstate_e     power_state;
    int          num_errors = 0, compares = 0;
    row_s rows [6] = '{'{0, 12'h008, 0, 32'h7, 32'h2, 0}, '{0, 12'h010, 0, '1, '1, 0},
        '{1, 12'h01C, 32'h80, 0, 0, 0}, '{0, 12'h01C, 0, 32'hFF, 32'h80, 0},
        '{0, 12'h020, 0, '1, 0, 1}, '{1, 12'h006, 32'h1, 0, 0, 1}};
    always #25 core_clk = !core_clk;
    host_wake_model u_host (.core_clk, .hold_reset, .drop_supply, .reset_pin_n,
        .supply_ok, .lf_osc_in, .lf_osc_out);
    power_mode_wake_control #(.NPIN(25), .CAL_CYC(4)) u_dut (.core_clk, .rstn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .reset_pin_n,
        .supply_ok, .temp_out_of_range, .gpio_in, .modem_ready, .stock_fw(1'b1),
        .lf_osc_in, .lf_osc_out, .radio_event, .tag_field_detect, .lp_comp_event,
        .sensor_event, .save_done(1'b0), .linear_regulator_mode, .buck_en,
        .rc_osc_en, .xtal_drive_en, .rc_cal_start, .core_reset_n, .ram_retain_all,
        .ram_retain_sect, .periph_lp_en, .save_req, .detach_req, .rtc_event,
        .tag_passive_only, .power_state);
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // entered and left just after a rising edge; one idle cycle between transfers
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int i;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) check("pready", 0, 1);
        if (i == 20) give_verdict();
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic wait_st(pstate_e s, string n);
        int i;
        for (i = 0; i < 4000 && power_state !== s; i++) @(posedge core_clk);
        check(n, 32'(power_state), 32'(s));
        if (i == 4000) give_verdict();
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge core_clk);
        check("ldo_at_reset", linear_regulator_mode, 1);
        check("tag_passive", tag_passive_only, 1);
        check("state_at_reset", 32'(power_state), 32'(PS_OFF));
        repeat (2) @(posedge core_clk);
        rstn <= 1;
        wait_st(PS_ACTIVE, "boot");
        foreach (rows[k]) begin
            apb(rows[k].w, rows[k].a, rows[k].d);
            check("prdata", rd & rows[k].m, rows[k].x);
            check("pslverr", er, rows[k].e);
        end
        check("buck_heavy", buck_en, 1);
        apb(1, 12'h000, 32'h1);
        apb(0, 12'h000, 0);
        check("ldo_forced", {linear_regulator_mode, buck_en}, 2'b10);
        $display("test regulator done");
        for (int s = 0; s < 3; s++) begin
            apb(1, 12'h000, 32'h10 | (s << 1));
            apb(0, 12'h000, 0);
            check("lf_src", {rc_osc_en, xtal_drive_en}, {s == 1, s == 0});
        end
        apb(1, 12'h000, 32'h812);
        hit = 0;
        repeat (3500) begin
            @(posedge core_clk);
            #1 hit = hit | rc_cal_start;
        end
        check("rc_cal", hit, 1);
        $display("test lf clock done");
        apb(1, 12'h00C, 32'h1);
        wait_st(PS_STANDBY, "standby0");
        sensor_event <= 1;
        wait_st(PS_ACTIVE, "sensor_wake");
        sensor_event <= 0;
        apb(0, 12'h014, 0);
        apb(1, 12'h010, rd + 3);
        apb(1, 12'h00C, 32'h1);
        wait_st(PS_STANDBY, "standby");
        check("standby_lp", {periph_lp_en, core_reset_n}, 2'b11);
        wait_st(PS_ACTIVE, "rtc_wake");
        apb(1, 12'h00C, 32'h1);
        wait_st(PS_STANDBY, "standby2");
        radio_event <= 1;
        wait_st(PS_ACTIVE, "radio_wake");
        radio_event <= 0;
        $display("test standby done");
        apb(1, 12'h00C, 32'h2);
        wait_st(PS_SLEEP, "sleep");
        check("sleep_halt", core_reset_n, 0);
        tag_field_detect <= 1;
        wait_st(PS_BOOT, "sleep_reboot");
        tag_field_detect <= 0;
        wait_st(PS_ACTIVE, "tag_wake");
        apb(1, 12'h004, 32'h4);
        apb(1, 12'h00C, 32'h2);
        wait_st(PS_SLEEP, "sleep2");
        gpio_in[2] <= 1;
        repeat (20) @(posedge core_clk);
        gpio_in[2] <= 0;
        repeat (1500) @(posedge core_clk);
        check("glitch_kept", 32'(power_state), 32'(PS_SLEEP));
        gpio_in[2] <= 1;
        wait_st(PS_ACTIVE, "pin_wake");
        apb(1, 12'h000, 32'hC7A);
        gpio_in[3] <= 1;
        wait_st(PS_SLEEP, "pin_sleep");
        gpio_in[4] <= 1;
        wait_st(PS_BOOT, "latch_wake");
        wait_st(PS_ACTIVE, "latch_up");
        gpio_in[3] <= 0;
        wait_st(PS_SLEEP, "pin_sleep2");
        lp_comp_event <= 1;
        wait_st(PS_BOOT, "comp_wake");
        lp_comp_event <= 0;
        wait_st(PS_ACTIVE, "comp_up");
        $display("test sleep done");
        modem_ready <= 0;
        wait_st(PS_SAVE, "modem_save");
        wait_st(PS_SLEEP, "modem_off");
        modem_ready <= 1;
        wait_st(PS_ACTIVE, "modem_on");
        apb(1, 12'h00C, 32'h3);
        wait_st(PS_SAVE, "poweroff");
        check("save_detach", {save_req, detach_req}, 2'b11);
        wait_st(PS_BOOT, "soft_reset");
        wait_st(PS_ACTIVE, "soft_up");
        $display("test poweroff done");
        hold_reset <= 1;
        repeat (4) @(posedge core_clk);
        check("pin_reset", {core_reset_n, save_req}, 2'b00);
        hold_reset <= 0;
        wait_st(PS_ACTIVE, "pin_reset_up");
        apb(0, 12'h000, 0);
        check("ctrl_kept", rd, 32'hC7A);
        temp_out_of_range <= 1;
        wait_st(PS_SHUTDOWN, "temp_off");
        temp_out_of_range <= 0;
        wait_st(PS_ACTIVE, "temp_up");
        rstn <= 0;
        @(posedge core_clk);
        rstn <= 1;
        wait_st(PS_ACTIVE, "reboot");
        drop_supply <= 1;
        wait_st(PS_OFF, "brownout");
        check("no_save", save_req, 0);
        $display("test shutdown done");
        give_verdict();
    end
endmodule // tb
